// [verilog/nhr_pkg.sv]
// Shared constants, types and decode functions of the host register map
package nhr_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int CAM_ENTRIES = 16;
  localparam int CAM_PTR_W = 4;
  localparam int CAM_WORD_W = 48;
  localparam int CDC_W = 5;
  localparam int TALLY_COUNT = 3;
  localparam int CMD_SWRESET_BIT = 7;

  typedef logic [ADDR_W-1:0] nhr_addr_t;
  typedef logic [DATA_W-1:0] nhr_word_t;
  typedef logic [CAM_PTR_W-1:0] nhr_cam_ptr_t;
  typedef logic [CAM_WORD_W-1:0] nhr_cam_word_t;
  typedef logic [CDC_W-1:0] nhr_cdc_t;

  // Register offsets on the register select lines
  localparam nhr_addr_t OFF_COMMAND = 6'h00;
  localparam nhr_addr_t OFF_DATA_CONFIG = 6'h01;
  localparam nhr_addr_t OFF_RECEIVE_CONTROL = 6'h02;
  localparam nhr_addr_t OFF_TRANSMIT_CONTROL = 6'h03;
  localparam nhr_addr_t OFF_INTERRUPT_MASK = 6'h04;
  localparam nhr_addr_t OFF_INTERRUPT_STATUS = 6'h05;
  localparam nhr_addr_t OFF_TX_DESC_UPPER_BASE = 6'h06;
  localparam nhr_addr_t OFF_TX_DESC_CURRENT = 6'h07;
  localparam nhr_addr_t OFF_RX_DESC_UPPER_BASE = 6'h0D;
  localparam nhr_addr_t OFF_RX_DESC_CURRENT = 6'h0E;
  localparam nhr_addr_t OFF_END_OF_BUFFER_COUNT = 6'h13;
  localparam nhr_addr_t OFF_RX_RESOURCE_UPPER_BASE = 6'h14;
  localparam nhr_addr_t OFF_RESOURCE_START = 6'h15;
  localparam nhr_addr_t OFF_RESOURCE_END = 6'h16;
  localparam nhr_addr_t OFF_RESOURCE_READ_POINTER = 6'h17;
  localparam nhr_addr_t OFF_RESOURCE_WRITE_POINTER = 6'h18;
  localparam nhr_addr_t OFF_CAM_ENTRY_POINTER = 6'h21;
  localparam nhr_addr_t OFF_FILTER_PORT_HIGH = 6'h22;
  localparam nhr_addr_t OFF_FILTER_PORT_MID = 6'h23;
  localparam nhr_addr_t OFF_FILTER_PORT_LOW = 6'h24;
  localparam nhr_addr_t OFF_CAM_ENABLE_MASK = 6'h25;
  localparam nhr_addr_t OFF_CAM_DESCRIPTOR_POINTER = 6'h26;
  localparam nhr_addr_t OFF_CAM_DESCRIPTOR_COUNT = 6'h27;
  localparam nhr_addr_t OFF_SILICON_REVISION = 6'h28;
  localparam nhr_addr_t OFF_WATCHDOG_LOW = 6'h29;
  localparam nhr_addr_t OFF_WATCHDOG_HIGH = 6'h2A;
  localparam nhr_addr_t OFF_RECEIVE_SEQUENCE_COUNT = 6'h2B;
  localparam nhr_addr_t OFF_CHECKSUM_ERROR_TALLY = 6'h2C;
  localparam nhr_addr_t OFF_ALIGNMENT_ERROR_TALLY = 6'h2D;
  localparam nhr_addr_t OFF_MISSED_PACKET_TALLY = 6'h2E;
  localparam nhr_addr_t OFF_DATA_CONFIG_SECOND = 6'h3F;

  // Reset values
  localparam nhr_word_t REG_RESET = 16'h0000;
  localparam nhr_word_t CMD_RESET = nhr_word_t'(16'h0001 << CMD_SWRESET_BIT);
  localparam nhr_cdc_t CDC_RESET = 5'h00;

  // Plain read/write storage registers with no side effects
  function automatic logic isPlainAddr(input nhr_addr_t a);
    case (a)
      OFF_RECEIVE_CONTROL, OFF_TRANSMIT_CONTROL, OFF_INTERRUPT_MASK,
      OFF_TX_DESC_UPPER_BASE, OFF_TX_DESC_CURRENT, OFF_RX_DESC_UPPER_BASE,
      OFF_RX_DESC_CURRENT, OFF_END_OF_BUFFER_COUNT, OFF_RX_RESOURCE_UPPER_BASE,
      OFF_RESOURCE_START, OFF_RESOURCE_END, OFF_RESOURCE_READ_POINTER,
      OFF_RESOURCE_WRITE_POINTER, OFF_CAM_ENTRY_POINTER, OFF_CAM_DESCRIPTOR_POINTER,
      OFF_WATCHDOG_LOW, OFF_WATCHDOG_HIGH, OFF_RECEIVE_SEQUENCE_COUNT: isPlainAddr = 1'b1;
      default: isPlainAddr = 1'b0;
    endcase
  endfunction

  // Filter port offset to bit position inside a CAM entry
  function automatic int filterShift(input nhr_addr_t a);
    case (a)
      OFF_FILTER_PORT_HIGH: filterShift = 2 * DATA_W;
      OFF_FILTER_PORT_MID: filterShift = DATA_W;
      default: filterShift = 0;
    endcase
  endfunction

endpackage

// [verilog/nhr_cam_if.sv]
// Carrier between the register decoder and the address-filter memory
`timescale 1ns/1ps
`default_nettype none
interface nhr_cam_if;
  import nhr_pkg::*;
  logic writeEnable;
  nhr_cam_ptr_t writeEntry;
  nhr_cam_word_t writeData;
  nhr_cam_ptr_t readEntry;
  nhr_cam_word_t readData;

  modport ctrl (output writeEnable, output writeEntry, output writeData, output readEntry, input readData);
  modport mem (input writeEnable, input writeEntry, input writeData, input readEntry, output readData);
endinterface
`default_nettype wire

// [verilog/nhr_cam_mem.sv]
// Address-filter entry memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module nhr_cam_mem (
  input wire logic ref_clk,
  input wire logic reset_n,
  nhr_cam_if.mem camIf
);
  import nhr_pkg::*;

  nhr_cam_word_t entry [CAM_ENTRIES];
  nhr_cam_word_t readData_q;

  // Storage has no reset; contents come only from descriptor loads
  always_ff @(posedge ref_clk) begin
    if (camIf.writeEnable) begin
      entry[camIf.writeEntry] <= camIf.writeData;
    end
  end

  // Read data registered, so a pointer change shows one cycle later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      readData_q <= '0;
    end else begin
      readData_q <= entry[camIf.readEntry];
    end
  end

  assign camIf.readData = readData_q;
endmodule
`default_nettype wire

// [verilog/nhr_tally.sv]
// One 16-bit tally counter whose host writes store the inverse
`timescale 1ns/1ps
`default_nettype none
module nhr_tally (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic writeStrobe,
  input wire nhr_pkg::nhr_word_t writeData,
  input wire logic countEvent,
  output nhr_pkg::nhr_word_t count
);
  import nhr_pkg::*;

  nhr_word_t count_q;

  // Host write beats a same-cycle event; software expects its value to stick
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= REG_RESET;
    end else if (writeStrobe) begin
      count_q <= ~writeData; // R4
    end else if (countEvent) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign count = count_q;

  tallyInvert_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    writeStrobe |=> count_q == ~$past(writeData))
    else $error("tally did not store inverse of written value");
endmodule
`default_nettype wire

// [verilog/nhr_regs.sv]
// Host register decoder and register file of the network controller
//
// Overview of operation
// R1 - The host reaches a register with chip select and a six-bit address, and only that register is accessed.
// R2 - The three filter data ports give valid entry contents only while software reset is set.
// R3 - Both data configuration registers take writes only during software reset and ignore them otherwise.
// R4 - A host write to any tally counter stores the bitwise inverse, so writing all ones clears it.
// R5 - Commands, status, buffer pointers, counts and interrupt mask and status each have their own address.
// R6 - Filter memory is never written through its data ports, only by descriptor loads.
// R7 - Only the low five bits of the descriptor count are kept and used for counting.
// R8 - The software-reset bit of the command register gates every restricted read and write.
`timescale 1ns/1ps
`default_nettype none
module nhr_regs #(
  parameter nhr_pkg::nhr_word_t SILICON_REVISION = 16'h0001 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic chipSelect,
  input wire logic writeEnable,
  input wire nhr_pkg::nhr_addr_t registerSelectLines,
  input wire nhr_pkg::nhr_word_t dataIn,
  output nhr_pkg::nhr_word_t dataOut,
  output logic dataOe,
  input wire logic camLoadValid,
  input wire nhr_pkg::nhr_cam_ptr_t camLoadEntry,
  input wire nhr_pkg::nhr_cam_word_t camLoadData,
  input wire logic camEnableLoad,
  input wire nhr_pkg::nhr_word_t camEnableData,
  input wire logic cdcDecrement,
  input wire logic [nhr_pkg::TALLY_COUNT-1:0] tallyEvent,
  input wire nhr_pkg::nhr_word_t interruptEvents,
  output logic softwareReset,
  output nhr_pkg::nhr_word_t commandReg,
  output nhr_pkg::nhr_word_t dataConfigReg,
  output nhr_pkg::nhr_word_t dataConfigSecondReg,
  output nhr_pkg::nhr_word_t interruptMaskReg,
  output nhr_pkg::nhr_word_t camEnableMask,
  output nhr_pkg::nhr_cdc_t camDescriptorCount
);
  import nhr_pkg::*;

  nhr_word_t command_q;
  nhr_word_t dataConfig_q;
  nhr_word_t dataConfigSecond_q;
  nhr_word_t interruptStatus_q;
  nhr_word_t camEnable_q;
  nhr_cdc_t cdc_q;
  nhr_word_t dataOut_q;
  logic dataOe_q;
  nhr_word_t readValue;
  logic hostWrite;
  logic hostRead;
  logic swReset;
  wire nhr_word_t plainReg [64];
  wire nhr_word_t tallyCount [TALLY_COUNT];

  nhr_cam_if camIf ();

  // Host strobes; host logic shares ref_clk so no synchroniser is needed
  assign hostWrite = chipSelect && writeEnable;
  assign hostRead = chipSelect && !writeEnable;
  assign swReset = command_q[CMD_SWRESET_BIT]; // R8

  // Command register; controller comes up held in software reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      command_q <= CMD_RESET;
    end else if (hostWrite && registerSelectLines == OFF_COMMAND) begin // R1
      command_q <= dataIn;
    end
  end

  commandWrite_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
    hostWrite && registerSelectLines == OFF_COMMAND |=> command_q == $past(dataIn))
    else $error("command write not stored");

  // Data configuration, writable only while software reset holds
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataConfig_q <= REG_RESET;
    end else if (hostWrite && swReset && registerSelectLines == OFF_DATA_CONFIG) begin // R3
      dataConfig_q <= dataIn;
    end
  end

  // Second data configuration, same reset-only write guard
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataConfigSecond_q <= REG_RESET;
    end else if (hostWrite && swReset && registerSelectLines == OFF_DATA_CONFIG_SECOND) begin // R3
      dataConfigSecond_q <= dataIn;
    end
  end

  secondLocked_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    hostWrite && !swReset && registerSelectLines == OFF_DATA_CONFIG_SECOND |=> $stable(dataConfigSecond_q))
    else $error("second data config changed outside software reset");

  // Interrupt status: write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      interruptStatus_q <= REG_RESET;
    end else if (hostWrite && registerSelectLines == OFF_INTERRUPT_STATUS) begin // R5
      interruptStatus_q <= (interruptStatus_q & ~dataIn) | interruptEvents;
    end else begin
      interruptStatus_q <= interruptStatus_q | interruptEvents;
    end
  end

  // Only checked without events, since a same-cycle event keeps its bit set
  statusClear_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    hostWrite && registerSelectLines == OFF_INTERRUPT_STATUS && interruptEvents == REG_RESET
    |=> (interruptStatus_q & $past(dataIn)) == REG_RESET)
    else $error("interrupt status bit not cleared by write");

  // Filter enable mask; descriptor load outranks a host write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      camEnable_q <= REG_RESET;
    end else if (camEnableLoad) begin
      camEnable_q <= camEnableData;
    end else if (hostWrite && registerSelectLines == OFF_CAM_ENABLE_MASK) begin
      camEnable_q <= dataIn;
    end
  end

  maskLoad_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    camEnableLoad |=> camEnable_q == $past(camEnableData))
    else $error("filter enable mask load lost");

  // Descriptor count keeps five bits; counting stops at zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cdc_q <= CDC_RESET;
    end else if (hostWrite && registerSelectLines == OFF_CAM_DESCRIPTOR_COUNT) begin
      cdc_q <= dataIn[CDC_W-1:0]; // R7
    end else if (cdcDecrement && cdc_q != CDC_RESET) begin
      cdc_q <= cdc_q - 5'h01; // R7
    end
  end

  countWrite_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
    hostWrite && registerSelectLines == OFF_CAM_DESCRIPTOR_COUNT |=> cdc_q == $past(dataIn[CDC_W-1:0]))
    else $error("descriptor count write not truncated to five bits");

  // Plain storage registers, one per mapped address
  for (genvar i = 0; i < 64; i++) begin : gPlain
    if (isPlainAddr(nhr_addr_t'(i))) begin : gReg
      nhr_word_t value_q;
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          value_q <= REG_RESET;
        end else if (hostWrite && registerSelectLines == nhr_addr_t'(i)) begin // R5
          value_q <= dataIn;
        end
      end
      assign plainReg[i] = value_q;
    end else begin : gNone
      assign plainReg[i] = REG_RESET;
    end
  end

  // Tally counters at consecutive offsets
  for (genvar t = 0; t < TALLY_COUNT; t++) begin : gTally
    nhr_tally uTally (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .writeStrobe(hostWrite && registerSelectLines == nhr_addr_t'(OFF_CHECKSUM_ERROR_TALLY + t)), // R4
      .writeData(dataIn),
      .countEvent(tallyEvent[t]),
      .count(tallyCount[t])
    );
  end

  tallyRead_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    hostRead && registerSelectLines == OFF_CHECKSUM_ERROR_TALLY |=> dataOut == $past(tallyCount[0]))
    else $error("checksum tally read wrong value");

  // Filter memory: written only by descriptor loads, never by the host ports
  assign camIf.writeEnable = camLoadValid; // R6
  assign camIf.writeEntry = camLoadEntry;
  assign camIf.writeData = camLoadData;
  assign camIf.readEntry = plainReg[OFF_CAM_ENTRY_POINTER][CAM_PTR_W-1:0];

  nhr_cam_mem uCamMem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .camIf(camIf.mem)
  );

  // Read decode; unmapped offsets and outside-reset filter reads give zero
  always_comb begin
    readValue = REG_RESET;
    case (registerSelectLines) // R1
      OFF_COMMAND: readValue = command_q;
      OFF_DATA_CONFIG: readValue = dataConfig_q;
      OFF_DATA_CONFIG_SECOND: readValue = dataConfigSecond_q;
      OFF_INTERRUPT_STATUS: readValue = interruptStatus_q;
      OFF_CAM_ENABLE_MASK: readValue = camEnable_q;
      OFF_CAM_DESCRIPTOR_COUNT: readValue = {{(DATA_W-CDC_W){1'b0}}, cdc_q};
      OFF_SILICON_REVISION: readValue = SILICON_REVISION;
      OFF_CHECKSUM_ERROR_TALLY: readValue = tallyCount[0];
      OFF_ALIGNMENT_ERROR_TALLY: readValue = tallyCount[1];
      OFF_MISSED_PACKET_TALLY: readValue = tallyCount[2];
      OFF_FILTER_PORT_HIGH, OFF_FILTER_PORT_MID, OFF_FILTER_PORT_LOW: begin
        if (swReset) begin // R2
          readValue = nhr_word_t'(camIf.readData >> filterShift(registerSelectLines));
        end
      end
      default: readValue = plainReg[registerSelectLines];
    endcase
  end

  // Read data taken into a flop on the read request and held there until the next read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut_q <= REG_RESET;
      dataOe_q <= 1'b0;
    end else begin
      dataOe_q <= hostRead;
      if (hostRead) begin
        dataOut_q <= readValue;
      end
    end
  end

  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign softwareReset = swReset;
  assign commandReg = command_q;
  assign dataConfigReg = dataConfig_q;
  assign dataConfigSecondReg = dataConfigSecond_q;
  assign interruptMaskReg = plainReg[OFF_INTERRUPT_MASK];
  assign camEnableMask = camEnable_q;
  assign camDescriptorCount = cdc_q;

  // Read strobe stands exactly one cycle per read, never without one
  readStrobe_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    hostRead |=> dataOe)
    else $error("read strobe missing");

  strobeDrop_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    !hostRead |=> !dataOe)
    else $error("read strobe without read");

  revisionRead_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    hostRead && registerSelectLines == OFF_SILICON_REVISION |=> dataOut == SILICON_REVISION)
    else $error("revision read returned wrong value");

  // Gap above the tallies holds no register, so it must read as zero
  unmappedRead_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    hostRead && registerSelectLines > OFF_MISSED_PACKET_TALLY && registerSelectLines < OFF_DATA_CONFIG_SECOND
    |=> dataOut == REG_RESET)
    else $error("unmapped offset read not zero");

  plainRead_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    hostRead && registerSelectLines == OFF_INTERRUPT_MASK |=> dataOut == $past(plainReg[OFF_INTERRUPT_MASK]))
    else $error("interrupt mask read wrong value");

  filterMid_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    hostRead && swReset && registerSelectLines == OFF_FILTER_PORT_MID
    |=> dataOut == $past(camIf.readData[2*DATA_W-1:DATA_W]))
    else $error("filter port mid read wrong slice");

  commandRead_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    hostRead && registerSelectLines == OFF_COMMAND |=> dataOe && dataOut == $past(command_q))
    else $error("command read returned wrong data");

  filterHidden_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    hostRead && !swReset && registerSelectLines == OFF_FILTER_PORT_LOW |=> dataOut == REG_RESET)
    else $error("filter port readable outside software reset");

  filterVisible_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    hostRead && swReset && registerSelectLines == OFF_FILTER_PORT_HIGH
    |=> dataOut == $past(camIf.readData[3*DATA_W-1:2*DATA_W]))
    else $error("filter port high read wrong slice");

  configLocked_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    hostWrite && !swReset && registerSelectLines == OFF_DATA_CONFIG |=> $stable(dataConfig_q))
    else $error("data config changed outside software reset");

  configOpen_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    hostWrite && swReset && registerSelectLines == OFF_DATA_CONFIG_SECOND
    |=> dataConfigSecond_q == $past(dataIn))
    else $error("second data config missed reset-mode write");

  tallyClear_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    hostWrite && registerSelectLines == OFF_MISSED_PACKET_TALLY && dataIn == 16'hFFFF
    |=> tallyCount[2] == REG_RESET)
    else $error("all-ones write did not clear missed packet tally");

  statusSetWins_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    (interruptEvents != REG_RESET) |=> (interruptStatus_q & $past(interruptEvents)) == $past(interruptEvents))
    else $error("interrupt event lost");

  camHostWrite_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
    camIf.writeEnable |-> camLoadValid)
    else $error("filter memory written without descriptor load");

  countFloor_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
    cdc_q == CDC_RESET && cdcDecrement && !hostWrite |=> cdc_q == CDC_RESET)
    else $error("descriptor count wrapped below zero");
endmodule
`default_nettype wire

// [tb/nhr_host_model.sv]
// Host processor model that reaches registers through chip select
`timescale 1ns/1ps
`default_nettype none
module nhr_host_model (
  input wire logic ref_clk,
  output logic chipSelect,
  output logic writeEnable,
  output nhr_pkg::nhr_addr_t registerSelectLines,
  output nhr_pkg::nhr_word_t dataIn,
  input wire nhr_pkg::nhr_word_t dataOut,
  input wire logic dataOe
);
  import nhr_pkg::*;

  // Quiet bus at time zero
  initial begin
    chipSelect = 1'b0;
    writeEnable = 1'b0;
    registerSelectLines = 6'h15;
    dataIn = 16'h5A5A;
  end

  // Released lines toggle so a stale address or datum never looks valid
  task automatic idle();
    chipSelect = 1'b0;
    writeEnable = 1'b0;
    registerSelectLines = ~registerSelectLines;
    dataIn = ~dataIn;
  endtask

  // Write: held across one rising edge, released at the next falling edge
  task automatic wr(input nhr_addr_t a, input nhr_word_t d);
    @(negedge ref_clk);
    chipSelect = 1'b1;
    writeEnable = 1'b1;
    registerSelectLines = a;
    dataIn = d;
    @(negedge ref_clk);
    idle();
  endtask

  // Read: answer stands in the cycle after the taking edge
  task automatic rd(input nhr_addr_t a, output nhr_word_t d, output logic ok);
    @(negedge ref_clk);
    chipSelect = 1'b1;
    writeEnable = 1'b0;
    registerSelectLines = a;
    @(negedge ref_clk);
    idle();
    ok = dataOe;
    d = dataOut;
  endtask
endmodule
`default_nettype wire

// [tb/test_nic_host_register_map.sv]
// Self-checking testbench of the host register map
`timescale 1ns/1ps
`default_nettype none
module test_nic_host_register_map;
  import nhr_pkg::*;
  localparam nhr_word_t REV = 16'h00A5; // Arbitrary revision value
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic chipSelect, writeEnable, dataOe, softwareReset, ok;
  nhr_addr_t registerSelectLines;
  nhr_word_t dataIn, dataOut, commandReg, dataConfigReg, dataConfigSecondReg, interruptMaskReg, camEnableMask;
  nhr_word_t camEnableData, interruptEvents, rdata, va, vb, tv;
  logic camLoadValid, camEnableLoad, cdcDecrement;
  logic [TALLY_COUNT-1:0] tallyEvent;
  nhr_cam_ptr_t camLoadEntry;
  nhr_cam_word_t camLoadData;
  nhr_cdc_t camDescriptorCount;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 30;
  nhr_addr_t plainAddr[18] = '{6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h0D, 6'h0E, 6'h13, 6'h14,
    6'h15, 6'h16, 6'h17, 6'h18, 6'h21, 6'h26, 6'h29, 6'h2A, 6'h2B};
  nhr_word_t plainVal[18];

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  nhr_host_model i_host (.ref_clk(ref_clk), .chipSelect(chipSelect), .writeEnable(writeEnable),
    .registerSelectLines(registerSelectLines), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

  nhr_regs #(.SILICON_REVISION(REV)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .chipSelect(chipSelect),
    .writeEnable(writeEnable), .registerSelectLines(registerSelectLines), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .camLoadValid(camLoadValid), .camLoadEntry(camLoadEntry), .camLoadData(camLoadData),
    .camEnableLoad(camEnableLoad), .camEnableData(camEnableData), .cdcDecrement(cdcDecrement),
    .tallyEvent(tallyEvent), .interruptEvents(interruptEvents), .softwareReset(softwareReset),
    .commandReg(commandReg), .dataConfigReg(dataConfigReg), .dataConfigSecondReg(dataConfigSecondReg),
    .interruptMaskReg(interruptMaskReg), .camEnableMask(camEnableMask), .camDescriptorCount(camDescriptorCount));

  // Expected word of one filter port within an entry
  function automatic nhr_word_t portWord(input nhr_cam_word_t e, input int idx);
    return e[idx*16 +: 16];
  endfunction

  // Expected descriptor count: low five bits only
  function automatic nhr_word_t cdcExp(input nhr_word_t v);
    return {11'h000, v[4:0]};
  endfunction

  task automatic check16(input nhr_word_t got, input nhr_word_t exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  // Read through the host and compare strobe and data
  task automatic checkRd(input nhr_addr_t a, input nhr_word_t exp);
    i_host.rd(a, rdata, ok);
    checkBit(ok, 1'b1, "read strobe");
    check16(rdata, exp, "read data");
  endtask

  task automatic endTest(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    camLoadValid = 1'b0;
    camLoadEntry = 4'h0;
    camLoadData = '0;
    camEnableLoad = 1'b0;
    camEnableData = 16'h0000;
    cdcDecrement = 1'b0;
    tallyEvent = '0;
    interruptEvents = 16'h0000;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    checkRd(OFF_COMMAND, CMD_RESET);
    checkBit(softwareReset, 1'b1, "reset state");
    check16(commandReg, CMD_RESET, "command port");
    endTest("reset");
    // Fill every plain register, then read all, so aliasing shows up
    foreach (plainAddr[i]) begin
      plainVal[i] = nhr_word_t'($random(seed));
      i_host.wr(plainAddr[i], plainVal[i]);
    end
    foreach (plainAddr[i]) checkRd(plainAddr[i], plainVal[i]);
    check16(interruptMaskReg, plainVal[2], "mask port");
    endTest("plain");
    va = nhr_word_t'($random(seed));
    vb = nhr_word_t'($random(seed));
    i_host.wr(OFF_DATA_CONFIG, va);
    i_host.wr(OFF_DATA_CONFIG_SECOND, vb);
    checkRd(OFF_DATA_CONFIG, va);
    checkRd(OFF_DATA_CONFIG_SECOND, vb);
    check16(dataConfigReg, va, "config port");
    check16(dataConfigSecondReg, vb, "config2 port");
    endTest("config");
    // Descriptor-side load of entry 5, then host reads through the ports
    @(negedge ref_clk);
    camLoadValid = 1'b1;
    camLoadEntry = 4'h5;
    camLoadData = {nhr_word_t'($random(seed)), $random(seed)};
    @(negedge ref_clk);
    camLoadValid = 1'b0;
    i_host.wr(OFF_CAM_ENTRY_POINTER, 16'h0005);
    for (int j = 0; j < 3; j++) checkRd(nhr_addr_t'(OFF_FILTER_PORT_HIGH + j), portWord(camLoadData, 2 - j));
    i_host.wr(OFF_FILTER_PORT_MID, ~portWord(camLoadData, 1));
    checkRd(OFF_FILTER_PORT_MID, portWord(camLoadData, 1));
    endTest("filter");
    for (int k = 0; k < 3; k++) begin
      tv = nhr_word_t'($random(seed));
      i_host.wr(nhr_addr_t'(OFF_CHECKSUM_ERROR_TALLY + k), tv);
      checkRd(nhr_addr_t'(OFF_CHECKSUM_ERROR_TALLY + k), ~tv);
      @(negedge ref_clk);
      tallyEvent = 3'b001 << k;
      @(negedge ref_clk);
      tallyEvent = '0;
      checkRd(nhr_addr_t'(OFF_CHECKSUM_ERROR_TALLY + k), nhr_word_t'(~tv + 16'h0001));
      i_host.wr(nhr_addr_t'(OFF_CHECKSUM_ERROR_TALLY + k), 16'hFFFF);
      checkRd(nhr_addr_t'(OFF_CHECKSUM_ERROR_TALLY + k), 16'h0000);
    end
    endTest("tally");
    i_host.wr(OFF_CAM_DESCRIPTOR_COUNT, 16'hFFE3);
    checkRd(OFF_CAM_DESCRIPTOR_COUNT, cdcExp(16'hFFE3));
    @(negedge ref_clk);
    cdcDecrement = 1'b1;
    @(negedge ref_clk);
    cdcDecrement = 1'b0;
    check16({11'h000, camDescriptorCount}, cdcExp(16'h0002), "count port");
    // Three more decrements from two: the count must rest at zero
    @(negedge ref_clk);
    cdcDecrement = 1'b1;
    repeat (3) @(negedge ref_clk);
    cdcDecrement = 1'b0;
    check16({11'h000, camDescriptorCount}, 16'h0000, "count floor");
    endTest("count");
    checkRd(OFF_SILICON_REVISION, REV);
    checkRd(6'h30, 16'h0000);
    @(negedge ref_clk);
    camEnableLoad = 1'b1;
    camEnableData = nhr_word_t'($random(seed));
    interruptEvents = 16'h0008;
    @(negedge ref_clk);
    camEnableLoad = 1'b0;
    interruptEvents = 16'h0000;
    checkRd(OFF_CAM_ENABLE_MASK, camEnableData);
    check16(camEnableMask, camEnableData, "enable port");
    checkRd(OFF_INTERRUPT_STATUS, 16'h0008);
    i_host.wr(OFF_INTERRUPT_STATUS, 16'h0008);
    checkRd(OFF_INTERRUPT_STATUS, 16'h0000);
    endTest("misc");
    // Leave software reset: guarded places must now refuse
    i_host.wr(OFF_COMMAND, 16'h0000);
    checkBit(softwareReset, 1'b0, "reset left");
    check16(commandReg, 16'h0000, "command port");
    i_host.wr(OFF_DATA_CONFIG, ~va);
    i_host.wr(OFF_DATA_CONFIG_SECOND, ~vb);
    checkRd(OFF_DATA_CONFIG, va);
    checkRd(OFF_DATA_CONFIG_SECOND, vb);
    checkRd(OFF_FILTER_PORT_LOW, 16'h0000);
    endTest("running");
    // Second reset in mid-run: registers go back to their reset values
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    checkBit(softwareReset, 1'b1, "reset again");
    checkRd(OFF_COMMAND, CMD_RESET);
    checkRd(plainAddr[0], 16'h0000);
    checkRd(OFF_DATA_CONFIG, 16'h0000);
    endTest("rereset");
    complete_run();
  end
endmodule
`default_nettype wire
